// ==== rtl/ufl_params.svh ====
`ifndef UFL_PARAMS_SVH
`define UFL_PARAMS_SVH
// ==========================================================================
// Register offsets, stored as word indices. Byte address is four times each.
`define UFL_IDX_CTRL      4'h2
`define UFL_IDX_AUX       4'h3
`define UFL_IDX_STATUS    4'h4
`define UFL_IDX_MASK      4'h5
`define UFL_IDX_TXDATA    4'h6
`define UFL_IDX_RXDATA    4'h7
`define UFL_IDX_BAUD      4'h8
// ==========================================================================
// Field positions of the frame loop control register.
`define UFL_B_LOOP        3'd7
`define UFL_B_WAITDIS     3'd6
`define UFL_B_RECEIVER_SOURCE_SELECT        3'd5
`define UFL_B_NINE        3'd4
`define UFL_B_WAKE        3'd3
`define UFL_B_ILT         3'd2
`define UFL_B_PAR         3'd1
`define UFL_B_ODD         3'd0
// Auxiliary control: 0 tx enable, 1 rx enable, 2 standby, 3 direction.
`define UFL_B_TXEN        2'd0
`define UFL_B_RXEN        2'd1
`define UFL_B_STBY        2'd2
`define UFL_B_DIR         2'd3
// Status bits: 0 tx done, 1 rx full, 2 idle, 3 parity error, 4 frame error.
`define UFL_NSTAT         5
`define UFL_S_TXDONE      3'd0
`define UFL_S_RXFULL      3'd1
`define UFL_S_IDLE        3'd2
`define UFL_S_PERR        3'd3
`define UFL_S_FERR        3'd4
// ==========================================================================
// Reset values and timing.
`define UFL_CTRL_RST      8'h00
`define UFL_BAUD_RST      16'h0364
`define UFL_OSR           4'hf
`define UFL_IDLE_BITS     4'ha
`endif

// ==== rtl/ufl_pkg.sv ====
package ufl_pkg;
  // Serial engine phases shared by transmitter and receiver.
  typedef enum logic [2:0] {
    UFL_IDLE, UFL_START, UFL_DATA, UFL_STOP
  } ufl_phase_t;
endpackage

// ==== rtl/ufl_tx.sv ====
`timescale 1ns/10ps
`include "ufl_params.svh"
module ufl_tx (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       tick_i,
  input  wire logic       start_i,
  input  wire logic [8:0] data_i,
  input  wire logic       nine_i,
  input  wire logic       par_i,
  input  wire logic       odd_i,
  output logic            line_o,
  output logic            busy_o,
  output logic            done_o
);
  ufl_pkg::ufl_phase_t state_r;
  logic [9:0]          shift_r;
  logic [3:0]          cnt_r;
  logic [3:0]          os_r;
  logic [3:0]          nbits;
  logic [8:0]          frame;
  logic                parity;

  // ========================================================================
  // Frame build: parity replaces the top character bit.
  assign nbits  = nine_i ? 4'd9 : 4'd8;
  assign parity = (nine_i ? ^data_i[7:0] : ^data_i[6:0]) ^ odd_i;
  assign frame  = !par_i ? data_i :
                  nine_i ? {parity, data_i[7:0]} :
                           {1'b0, parity, data_i[6:0]};
  assign busy_o = (state_r != ufl_pkg::UFL_IDLE);

  // Bit sequencer, one bit per sixteen oversample ticks.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ufl_pkg::UFL_IDLE;
      shift_r <= 10'h000;
      cnt_r   <= 4'h0;
      os_r    <= 4'h0;
      line_o  <= 1'b1;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        ufl_pkg::UFL_IDLE: begin
          line_o <= 1'b1;
          if (start_i) begin
            shift_r <= {1'b1, frame};
            state_r <= ufl_pkg::UFL_START;
            os_r    <= 4'h0;
          end
        end
        ufl_pkg::UFL_START: begin
          line_o <= 1'b0;
          if (tick_i) begin
            os_r <= os_r + 4'h1;
            if (os_r == `UFL_OSR) begin
              state_r <= ufl_pkg::UFL_DATA;
              cnt_r   <= 4'h0;
            end
          end
        end
        ufl_pkg::UFL_DATA: begin
          line_o <= shift_r[0];
          if (tick_i) begin
            os_r <= os_r + 4'h1;
            if (os_r == `UFL_OSR) begin
              shift_r <= {1'b1, shift_r[9:1]};
              cnt_r   <= cnt_r + 4'h1;
              if (cnt_r == nbits - 4'h1) begin
                state_r <= ufl_pkg::UFL_STOP;
              end
            end
          end
        end
        default: begin
          line_o <= 1'b1;
          if (tick_i) begin
            os_r <= os_r + 4'h1;
            if (os_r == `UFL_OSR) begin
              state_r <= ufl_pkg::UFL_IDLE;
              done_o  <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule

// ==== rtl/ufl_rx.sv ====
`timescale 1ns/10ps
`include "ufl_params.svh"
module ufl_rx (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       tick_i,
  input  wire logic       en_i,
  input  wire logic       line_i,
  input  wire logic       nine_i,
  input  wire logic       par_i,
  input  wire logic       odd_i,
  input  wire logic       ilt_i,
  output logic [8:0]      data_o,
  output logic            done_o,
  output logic            perr_o,
  output logic            ferr_o,
  output logic            idle_o
);
  ufl_pkg::ufl_phase_t state_r;
  logic [8:0]          shift_r;
  logic [3:0]          cnt_r;
  logic [3:0]          os_r;
  logic [3:0]          idle_r;
  logic [3:0]          ios_r;
  logic                armed_r;
  logic [3:0]          nbits;
  logic                mid;
  logic                last;
  logic [8:0]          word;
  logic                perr;
  logic                perr_r;

  // ========================================================================
  // Sampling decode and parity check over character including parity bit.
  assign nbits = nine_i ? 4'd9 : 4'd8;
  assign mid   = tick_i && (os_r == 4'h7);
  assign last  = tick_i && (os_r == `UFL_OSR);
  assign word  = nine_i ? {line_i, shift_r[8:1]} : {1'b0, line_i, shift_r[8:2]};
  assign perr  = par_i && ((^word) != odd_i);

  // Receive sequencer.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ufl_pkg::UFL_IDLE;
      shift_r <= 9'h000;
      cnt_r   <= 4'h0;
      os_r    <= 4'h0;
      data_o  <= 9'h000;
      done_o  <= 1'b0;
      perr_o  <= 1'b0;
      ferr_o  <= 1'b0;
      perr_r  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      perr_o <= 1'b0;
      ferr_o <= 1'b0;
      if (tick_i) begin
        os_r <= os_r + 4'h1;
      end
      case (state_r)
        ufl_pkg::UFL_IDLE: begin
          os_r <= 4'h0;
          if (en_i && !line_i) begin
            state_r <= ufl_pkg::UFL_START;
          end
        end
        ufl_pkg::UFL_START: begin
          if (mid) begin
            state_r <= line_i ? ufl_pkg::UFL_IDLE : ufl_pkg::UFL_DATA;
            os_r    <= 4'h8;
            cnt_r   <= 4'h0;
          end
        end
        ufl_pkg::UFL_DATA: begin
          if (mid) begin
            shift_r <= {line_i, shift_r[8:1]};
            cnt_r   <= cnt_r + 4'h1;
            if (cnt_r == nbits - 4'h1) begin
              state_r <= ufl_pkg::UFL_STOP;
              data_o  <= word;
              perr_r  <= perr;
            end
          end
        end
        default: begin
          if (mid) begin
            state_r <= ufl_pkg::UFL_IDLE;
            done_o  <= 1'b1;
            ferr_o  <= !line_i;
            perr_o  <= perr_r; // Reported with done so status can pair them.
          end
        end
      endcase
    end
  end

  // Idle counter: counts high bit times, origin chosen by type bit.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_r  <= 4'h0;
      ios_r   <= 4'h0;
      armed_r <= 1'b0;
      idle_o  <= 1'b0;
    end else begin
      idle_o <= 1'b0;
      if (!en_i || !line_i ||
          (ilt_i && state_r != ufl_pkg::UFL_IDLE)) begin
        idle_r <= 4'h0;
        ios_r  <= 4'h0;
        if (!line_i) begin
          armed_r <= 1'b1;
        end
      end else if (tick_i) begin
        ios_r <= ios_r + 4'h1;
        if (ios_r == `UFL_OSR && idle_r != `UFL_IDLE_BITS) begin
          idle_r <= idle_r + 4'h1;
          if (idle_r == `UFL_IDLE_BITS - 4'h1 && armed_r) begin
            idle_o  <= 1'b1;
            armed_r <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ==== rtl/ufl_top.sv ====
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "ufl_params.svh"
module ufl_top (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        wait_mode_i,
  input  wire logic        rx_pin_i,
  input  wire logic        tx_pin_i,
  output logic             tx_pin_o,
  output logic             tx_pin_oe_o,
  output logic             irq_o
);
  logic [7:0]  ctrl_r;
  logic [3:0]  aux_r;
  logic [4:0]  status_r;
  logic [4:0]  mask_r;
  logic [8:0]  txdata_r;
  logic [8:0]  rxdata_r;
  logic [15:0] baud_r;
  logic [15:0] bcnt_r;
  logic        tick_r;
  logic        txgo_r;
  logic        rx_line_r;

  // ==========================================================================
  // Option decode.
  logic loop_select;
  logic wait_mode_disable;
  logic receiver_source_select;
  logic nine_bit;
  logic wake_addr;
  logic idle_count_origin;
  logic parity_on;
  logic parity_odd_select;
  logic tx_en;
  logic rx_en;
  logic receiver_standby;
  logic single_line_direction;
  logic halted;
  logic single_wire;

  assign loop_select            = ctrl_r[`UFL_B_LOOP];
  assign wait_mode_disable      = ctrl_r[`UFL_B_WAITDIS];
  assign receiver_source_select = ctrl_r[`UFL_B_RECEIVER_SOURCE_SELECT];
  assign nine_bit               = ctrl_r[`UFL_B_NINE];
  assign wake_addr              = ctrl_r[`UFL_B_WAKE];
  assign idle_count_origin      = ctrl_r[`UFL_B_ILT];
  assign parity_on              = ctrl_r[`UFL_B_PAR];
  assign parity_odd_select      = ctrl_r[`UFL_B_ODD];
  assign tx_en                  = aux_r[`UFL_B_TXEN];
  assign rx_en                  = aux_r[`UFL_B_RXEN];
  assign receiver_standby       = aux_r[`UFL_B_STBY];
  assign single_line_direction  = aux_r[`UFL_B_DIR];
  assign halted      = wait_mode_i && wait_mode_disable;
  assign single_wire = loop_select && receiver_source_select;

  // ==========================================================================
  // APB decode.
  logic [5:0] widx;
  logic       aligned;
  logic       access;
  logic       wr;
  logic       hit_ctrl;
  logic       hit_aux;
  logic       hit_stat;
  logic       hit_mask;
  logic       hit_tx;
  logic       hit_rx;
  logic       hit_baud;
  logic       mapped;
  logic [31:0] rdata;

  assign widx     = paddr_i[7:2];
  assign aligned  = (paddr_i[1:0] == 2'b00);
  assign access   = psel_i && penable_i && pready_o;
  assign hit_ctrl = aligned && (widx == {2'b00, `UFL_IDX_CTRL});
  assign hit_aux  = aligned && (widx == {2'b00, `UFL_IDX_AUX});
  assign hit_stat = aligned && (widx == {2'b00, `UFL_IDX_STATUS});
  assign hit_mask = aligned && (widx == {2'b00, `UFL_IDX_MASK});
  assign hit_tx   = aligned && (widx == {2'b00, `UFL_IDX_TXDATA});
  assign hit_rx   = aligned && (widx == {2'b00, `UFL_IDX_RXDATA});
  assign hit_baud = aligned && (widx == {2'b00, `UFL_IDX_BAUD});
  assign mapped   = hit_ctrl || hit_aux || hit_stat || hit_mask ||
                    hit_tx || hit_rx || hit_baud;
  assign wr       = access && pwrite_i;

  // Read mux, unused upper bits read zero.
  always_comb begin
    if (hit_ctrl) begin
      rdata = {24'h000000, ctrl_r};
    end else if (hit_aux) begin
      rdata = {28'h0000000, aux_r};
    end else if (hit_stat) begin
      rdata = {27'h0000000, status_r};
    end else if (hit_mask) begin
      rdata = {27'h0000000, mask_r};
    end else if (hit_tx) begin
      rdata = {23'h000000, txdata_r};
    end else if (hit_rx) begin
      rdata = {23'h000000, rxdata_r};
    end else if (hit_baud) begin
      rdata = {16'h0000, baud_r};
    end else begin
      rdata = 32'h00000000;
    end
  end

  // Slave answers after one wait cycle: setup, wait, then ready.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      prdata_o  <= rdata;
      pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
    end
  end

  // ==========================================================================
  // Engines and pin routing.
  logic       tx_line;
  logic       tx_busy;
  logic       tx_done;
  logic [8:0] rx_data;
  logic       rx_done;
  logic       rx_perr;
  logic       rx_ferr;
  logic       rx_idle;
  logic       rx_in;
  logic       rx_run;
  logic       drive;
  logic       wake_idle;
  logic       wake_mark;
  logic [4:0] events;

  // Receiver input: pin, internal loop, or shared transmit pin node.
  assign rx_in = !loop_select ? rx_pin_i :
                 receiver_source_select ? tx_pin_i :
                 tx_line;
  assign rx_run = rx_en && !halted;
  // Single wire drives only when direction says out.
  assign drive = tx_en && !halted &&
                 (!single_wire || single_line_direction);
  assign wake_idle = !wake_addr && rx_idle;
  assign wake_mark = wake_addr && rx_done &&
                     (nine_bit ? rx_data[8] : rx_data[7]);
  assign events = {rx_done && rx_ferr,
                   rx_done && rx_perr,
                   rx_idle,
                   rx_done && !(receiver_standby && !wake_mark),
                   tx_done};

  // Registered receive line keeps the combinational loop off the pins.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_line_r <= 1'b1;
    end else begin
      rx_line_r <= rx_in;
    end
  end

  // Oversample tick divider.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (halted || bcnt_r >= baud_r) begin
        bcnt_r <= 16'h0000;
        tick_r <= !halted;
      end else begin
        bcnt_r <= bcnt_r + 16'h0001;
      end
    end
  end

  ufl_tx u_tx (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick_r),
    .start_i (txgo_r && tx_en && !halted),
    .data_i  (txdata_r),
    .nine_i  (nine_bit),
    .par_i   (parity_on),
    .odd_i   (parity_odd_select),
    .line_o  (tx_line),
    .busy_o  (tx_busy),
    .done_o  (tx_done)
  );

  ufl_rx u_rx (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tick_i  (tick_r),
    .en_i    (rx_run),
    .line_i  (rx_line_r),
    .nine_i  (nine_bit),
    .par_i   (parity_on),
    .odd_i   (parity_odd_select),
    .ilt_i   (idle_count_origin),
    .data_o  (rx_data),
    .done_o  (rx_done),
    .perr_o  (rx_perr),
    .ferr_o  (rx_ferr),
    .idle_o  (rx_idle)
  );

  // ==========================================================================
  // Registers.
  // Option register, all zero after reset.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `UFL_CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_r <= pwdata_i[7:0];
    end
  end

  // Auxiliary control; hardware wakeup clears standby and wins over write.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_r <= 4'h0;
    end else begin
      if (wr && hit_aux) begin
        aux_r <= pwdata_i[3:0];
      end
      if (receiver_standby && (wake_idle || wake_mark)) begin
        aux_r[`UFL_B_STBY] <= 1'b0;
      end
    end
  end

  // Sticky status, write one to clear, new events win.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_r <= 5'h00;
    end else begin
      status_r <= (status_r & ~((wr && hit_stat) ? pwdata_i[4:0] : 5'h00))
                  | events;
    end
  end

  // Mask, baud divisor and transmit data.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r   <= 5'h00;
      baud_r   <= `UFL_BAUD_RST;
      txdata_r <= 9'h000;
      txgo_r   <= 1'b0;
    end else begin
      if (wr && hit_mask) begin
        mask_r <= pwdata_i[4:0];
      end
      if (wr && hit_baud) begin
        baud_r <= pwdata_i[15:0];
      end
      if (wr && hit_tx) begin
        txdata_r <= pwdata_i[8:0];
        txgo_r   <= 1'b1;
      end else if (tx_busy) begin
        txgo_r <= 1'b0;
      end
    end
  end

  // Receive data held unless standby suppresses non-waking characters.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxdata_r <= 9'h000;
    end else if (rx_done && !(receiver_standby && !wake_mark)) begin
      rxdata_r <= rx_data;
    end
  end

  // Pin and interrupt outputs, all registered.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_pin_o    <= 1'b1;
      tx_pin_oe_o <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      tx_pin_o    <= tx_line;
      tx_pin_oe_o <= drive;
      irq_o       <= |(status_r & mask_r);
    end
  end
endmodule

// ==== tb/ufl_monitor.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Bus and pin checker for the serial port top.
module ufl_monitor (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        wait_mode_i,
  input wire logic        rx_pin_i,
  input wire logic        tx_pin_i,
  input wire logic        tx_pin_o,
  input wire logic        tx_pin_oe_o,
  input wire logic        irq_o
);
  logic [7:0] ctrl_r;
  logic [3:0] aux_r;
  logic       wr_w;

  // A write access that completes without error.
  assign wr_w = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

  // Shadows of the option and auxiliary registers, kept from bus writes.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= 8'h00;
      aux_r  <= 4'h0;
    end else if (wr_w && paddr_i == 8'h08) begin
      ctrl_r <= pwdata_i[7:0];
    end else if (wr_w && paddr_i == 8'h0c) begin
      aux_r  <= pwdata_i[3:0];
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence wait_s;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence answer_s;
    pready_o ##1 !pready_o;
  endsequence

  answer_wait_a: assert property (wait_s |=> answer_s)
    else $error("access not answered after one wait state");
  ready_access_a: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready outside an access phase");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  bad_addr_a: assert property (pready_o && (paddr_i > 8'h20
    || paddr_i[1:0] != 2'h0) |-> pslverr_o && (pwrite_i || prdata_o == 0))
    else $error("unmapped access not refused");
  ctrl_read_a: assert property (pready_o && !pwrite_i && paddr_i == 8'h08
    |-> prdata_o == {24'h0, ctrl_r}) else $error("option readback wrong");
  wait_halt_a: assert property ((ctrl_r[6] && wait_mode_i)[*3]
    |-> !tx_pin_oe_o) else $error("port drives while halted");
  wait_run_a: assert property ((!ctrl_r[6] && !ctrl_r[7] && aux_r[0])[*3]
    |-> tx_pin_oe_o) else $error("port not driving while enabled");
  listen_oe_a: assert property ((ctrl_r[7] && ctrl_r[5] && !aux_r[3])[*3]
    |-> !tx_pin_oe_o) else $error("single wire drives while listening");
  tx_off_a: assert property ((!aux_r[0])[*3] |-> !tx_pin_oe_o)
    else $error("pin driven with transmitter off");
  reset_idle_a: assert property ($rose(rst_b_i) |-> tx_pin_o && !tx_pin_oe_o)
    else $error("pin not idle after reset");
endmodule

bind ufl_top ufl_monitor u_mon (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .wait_mode_i(wait_mode_i),
  .rx_pin_i(rx_pin_i), .tx_pin_i(tx_pin_i), .tx_pin_o(tx_pin_o),
  .tx_pin_oe_o(tx_pin_oe_o), .irq_o(irq_o));

// ==== tb/ufl_node.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Remote serial node: sends frames and captures frames on a watched line.
module ufl_node (
  input  wire logic  clock_i,
  input  wire logic  line_i,
  input  wire logic  nine_i,
  output logic       line_o,
  output logic [8:0] got_o
);
  // The line rests at its pull-up level.
  initial begin
    line_o = 1'b1;
    got_o  = 9'h000;
  end

  // Sends start, n data bits LSB first, then stop; sixteen clocks a bit.
  task automatic send(input logic [8:0] d, input int n);
    line_o <= 1'b0;
    repeat (16) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      line_o <= d[i];
      repeat (16) @(posedge clock_i);
    end
    line_o <= 1'b1;
    repeat (16) @(posedge clock_i);
  endtask

  // Forces the line to a level, used to show that a pin is ignored.
  task automatic hold(input logic v);
    line_o <= v;
  endtask

  // Captures each frame by sampling in the middle of every bit.
  always begin
    int         n;
    logic [8:0] t;
    @(negedge line_i);
    n = nine_i ? 9 : 8;
    t = 9'h000;
    repeat (8) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clock_i);
      t[i] = line_i;
    end
    got_o = t;
    repeat (16) @(posedge clock_i);
  end
endmodule

// ==== tb/ufl_top_tb.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Bench for the serial port option control.
module ufl_top_tb;
  logic        clock_i, rst_b_i, psel, penable, pwrite, wait_mode, nine;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, tx_pin, tx_oe, irq, node_line, tx_wire;
  logic [8:0]  got;
  int          mismatches, n_checks;
  logic [7:0]  cfg [6] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h12, 8'h13};

  // The shared transmit wire is driven by the port or by the node.
  assign tx_wire = tx_oe ? tx_pin : node_line;

  ufl_top u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .wait_mode_i(wait_mode), .rx_pin_i(node_line),
    .tx_pin_i(tx_wire), .tx_pin_o(tx_pin), .tx_pin_oe_o(tx_oe),
    .irq_o(irq));
  ufl_node u_node (.clock_i(clock_i), .line_i(tx_wire), .nine_i(nine),
    .line_o(node_line), .got_o(got));

  // Free-running clock, 10 ns period.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // One bus transfer: setup, access, then wait for ready.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clock_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // Ready is looked at mid-cycle, where it has settled; the answer is
    // taken then and the request is held through the next rising edge.
    do @(negedge clock_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    @(posedge clock_i);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] %0t: got %h, expected %h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bus(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    bus(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask

  // Waits a bounded time for the interrupt line.
  task automatic wait_irq;
    repeat (600) begin
      @(posedge clock_i);
      if (irq === 1'b1) break;
    end
    chk({31'h0, irq}, 32'h1);
  endtask

  // Options are only changed with transmitter and receiver off.
  task automatic mode(input logic [7:0] c, input logic [3:0] aux);
    wr(8'h0c, 32'h0);
    wr(8'h08, {24'h0, c});
    wr(8'h0c, {28'h0, aux});
    nine = c[4];
  endtask

  // Character as it appears on the line, parity in the top bit.
  function automatic logic [8:0] frame(input logic [8:0] d,
                                       input logic [7:0] c);
    logic [8:0] f;
    f = c[4] ? d : {1'b0, d[7:0]};
    if (c[1] && c[4]) f[8] = ^d[7:0] ^ c[0];
    if (c[1] && !c[4]) f[7] = ^d[6:0] ^ c[0];
    return f;
  endfunction

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (50000) @(posedge clock_i);
    mismatches++;
    $display("[FAIL] %0t: watchdog expired", $time);
    wrap_up();
  end

  // Main sequence of tests.
  initial begin
    logic [31:0] q;
    logic        e;
    {psel, penable, pwrite, wait_mode, nine, rst_b_i} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(8'h08, 32'h0);
    rd(8'h20, 32'h364);
    bus(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(8'h08, 32'hff);
    rd(8'h08, 32'hff);
    wr(8'h20, 32'h0);
    wr(8'h14, 32'h3);
    $display("test registers done");
    foreach (cfg[i]) begin
      mode(cfg[i], 4'h3);
      wr(8'h18, 32'h1a5);
      wait_irq();
      chk({23'h0, got}, {23'h0, frame(9'h1a5, cfg[i])});
      rd(8'h10, 32'h1);
      wr(8'h10, 32'h1f);
      repeat (2) @(posedge clock_i);
      chk({31'h0, irq}, 32'h0);
      u_node.send(frame(9'h0c3, cfg[i]), cfg[i][4] ? 9 : 8);
      wait_irq();
      rd(8'h1c, {23'h0, frame(9'h0c3, cfg[i])});
      repeat (200) @(posedge clock_i);
      wr(8'h10, 32'h1f);
    end
    $display("test framing done");
    for (int k = 0; k < 2; k++) begin
      mode({5'h0, k[0], 2'h2}, 4'h3);
      u_node.send(frame(9'h0c3, 8'h02) ^ 9'h080, 8);
      wait_irq();
      rd(8'h10, 32'h0a);
      repeat (200) @(posedge clock_i);
      rd(8'h10, 32'h0e);
      wr(8'h10, 32'h1f);
    end
    $display("test parity and idle done");
    mode(8'h80, 4'h3);
    u_node.hold(1'b0);
    wr(8'h18, 32'h3c);
    wait_irq();
    repeat (24) @(posedge clock_i);
    rd(8'h1c, 32'h3c);
    rd(8'h10, 32'h03);
    u_node.hold(1'b1);
    wr(8'h10, 32'h1f);
    $display("test loopback done");
    mode(8'ha0, 4'h3);
    repeat (4) @(posedge clock_i);
    chk({31'h0, tx_oe}, 32'h0);
    u_node.send(9'h077, 8);
    wait_irq();
    rd(8'h1c, 32'h77);
    wr(8'h10, 32'h1f);
    mode(8'ha0, 4'hb);
    wr(8'h18, 32'h1e);
    wait_irq();
    repeat (24) @(posedge clock_i);
    chk({23'h0, got}, 32'h1e);
    rd(8'h10, 32'h03);
    wr(8'h10, 32'h1f);
    $display("test single wire done");
    mode(8'h08, 4'h7);
    wr(8'h14, 32'h2);
    u_node.send(9'h012, 8);
    repeat (4) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    u_node.send(9'h092, 8);
    wait_irq();
    rd(8'h1c, 32'h92);
    rd(8'h0c, 32'h3);
    wr(8'h10, 32'h1f);
    $display("test standby done");
    mode(8'h40, 4'h1);
    wait_mode <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk({31'h0, tx_oe}, 32'h0);
    wait_mode <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk({31'h0, tx_oe}, 32'h1);
    mode(8'h00, 4'h1);
    wait_mode <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk({31'h0, tx_oe}, 32'h1);
    $display("test wait mode done");
    wrap_up();
  end
endmodule
